// ==== core/pmle_ctrl.sv ====
module pmle_ctrl
  import pmle_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  // wishbone classic slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // cpu side
  input  wire logic       instr_end,
  input  wire logic       irq_pending,
  input  wire logic       ram_we_req,
  input  wire logic       verify_active,
  input  wire logic [7:0] code_byte,
  // pins
  input  wire logic       reset_pin,
  input  wire logic       external_access_select,
  input  wire logic       ale_pin_in,
  input  wire logic       program_fetch_strobe_in,
  // outputs
  output logic            cpu_halt,
  output logic            periph_clk_en,
  output logic            osc_enable,
  output logic            ram_we,
  output logic            periph_reset,
  output logic            core_reset,
  output logic            ale_out,
  output logic            ale_oe,
  output logic            program_fetch_strobe,
  output logic            program_fetch_strobe_oe,
  output logic            port0_oe,
  output logic            weak_pullup,
  output logic            ea_latched,
  output logic            ext_no_internal,
  output logic            program_disable,
  output logic            verify_disable,
  output logic [7:0]      verify_data
);
  import pmle_pkg::*;

  localparam int RCNT_W = $clog2(RESET_HOLD_CLKS + 1);
  localparam int WCNT_W = $clog2(IDLE_RESUME_CLKS + 1);

  logic [1:0]  rst_sync;
  logic [1:0]  ea_sync;
  logic [1:0]  ale_sync;
  logic [1:0]  program_fetch_strobe_sync;
  logic [RCNT_W-1:0] rst_cnt;
  logic        hw_reset;
  logic        hw_reset_q;
  logic        emu_armed;
  pmle_state_t state;
  logic [WCNT_W-1:0] resume_cnt;
  logic        resume_win;
  logic        req_idle;
  logic        req_pd;
  logic [1:0]  lock_bits;
  logic [7:0]  key_mem [KEY_BYTES];
  logic [KEY_IDX_W-1:0] key_wr_idx;
  logic [KEY_IDX_W-1:0] key_rd_idx;
  logic        wb_hit;
  logic        wb_wr;
  logic        verify_q;

  // external pins pass two flops before use
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync  <= 2'h0;
      ea_sync   <= 2'h0;
      ale_sync  <= 2'h3;
      program_fetch_strobe_sync <= 2'h3;
    end else begin
      rst_sync  <= {rst_sync[0], reset_pin};
      ea_sync   <= {ea_sync[0], external_access_select};
      ale_sync  <= {ale_sync[0], ale_pin_in};
      program_fetch_strobe_sync <= {program_fetch_strobe_sync[0], program_fetch_strobe_in};
    end
  end

  // reset recognised after two machine cycles high; clock only runs with oscillator
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_cnt  <= '0;
      hw_reset <= 1'b0;
    end else if (!rst_sync[1]) begin
      rst_cnt  <= '0;
      hw_reset <= 1'b0;
    end else if (rst_cnt != RCNT_W'(RESET_HOLD_CLKS)) begin
      rst_cnt  <= rst_cnt + RCNT_W'(1);
    end else begin
      hw_reset <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hw_reset_q <= 1'b0;
    end else begin
      hw_reset_q <= hw_reset;
    end
  end

  // emulation entry: strobe low with fetch strobe high while reset held
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      emu_armed <= 1'b0;
    end else if (hw_reset) begin
      emu_armed <= !ale_sync[1] && program_fetch_strobe_sync[1];
    end else begin
      emu_armed <= 1'b0;
    end
  end

  // software requests latched from the bus, acted on at instruction end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      req_idle <= 1'b0;
      req_pd   <= 1'b0;
    end else if (hw_reset) begin
      req_idle <= 1'b0;
      req_pd   <= 1'b0;
    end else if (wb_wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
      req_idle <= wb_dat_i[CTRL_IDLE_BIT];
      req_pd   <= wb_dat_i[CTRL_PD_BIT];
    end else if (instr_end && state == PMLE_RUN && (req_idle || req_pd)) begin
      req_idle <= 1'b0;
      req_pd   <= 1'b0;
    end
  end

  // mode state machine
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= PMLE_RUN;
    end else begin
      case (state)
        PMLE_RUN: begin
          if (hw_reset_q && !hw_reset && emu_armed) begin
            state <= PMLE_EMULATE;
          end else if (instr_end && req_pd) begin
            state <= PMLE_PDOWN;
          end else if (instr_end && req_idle) begin
            state <= PMLE_IDLE;
          end
        end
        PMLE_IDLE: begin
          // the pin wakes the cpu at board_emulation_mode; recognition only follows two machine cycles later
          if (hw_reset || irq_pending || rst_sync[1]) begin
            state <= PMLE_RUN;
          end
        end
        PMLE_PDOWN: begin
          if (hw_reset) begin
            state <= PMLE_RUN;
          end
        end
        PMLE_EMULATE: begin
          if (hw_reset_q && !hw_reset && !emu_armed) begin
            state <= PMLE_RUN;
          end
        end
        default: state <= PMLE_RUN;
      endcase
    end
  end

  // resume window: idle left by reset before the reset sequence takes over
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resume_cnt <= '0;
      resume_win <= 1'b0;
    end else if (state == PMLE_IDLE && rst_sync[1] && !hw_reset) begin
      resume_win <= 1'b1;
      resume_cnt <= WCNT_W'(IDLE_RESUME_CLKS);
    end else if (resume_win && resume_cnt != '0 && !hw_reset) begin
      resume_cnt <= resume_cnt - WCNT_W'(1);
    end else begin
      resume_win <= 1'b0;
    end
  end

  // lock bits and key array, writes refused board_emulation_mode lock bit 1 is programmed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lock_bits  <= LOCK_RESET;
      key_wr_idx <= '0;
    end else if (wb_wr && wb_sel_i[0] && !lock_bits[LOCK_B1_BIT]) begin
      if (wb_adr_i == ADDR_LOCK) begin
        lock_bits <= lock_bits | wb_dat_i[1:0]; // programming only sets bits
      end else if (wb_adr_i == ADDR_KEYIDX) begin
        key_wr_idx <= wb_dat_i[KEY_IDX_W-1:0];
      end else if (wb_adr_i == ADDR_KEYDAT) begin
        key_wr_idx <= key_wr_idx + KEY_IDX_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (wb_wr && wb_sel_i[0] && !lock_bits[LOCK_B1_BIT]
        && wb_adr_i == ADDR_KEYDAT) begin
      key_mem[key_wr_idx] <= wb_dat_i[7:0];
    end
  end

  // access latch: no async value; it holds its power-up value until a pin reset with lock bit 1 programmed loads it
  always_ff @(posedge clock) begin
    if (hw_reset && lock_bits[LOCK_B1_BIT]) begin
      ea_latched <= ea_sync[1];
    end
  end

  // verify: xnor each byte with the next key (all ones when both lock bits are set), index restarts per verify run
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      key_rd_idx  <= '0;
      verify_q    <= 1'b0;
      verify_data <= 8'hFF;
    end else begin
      verify_q <= verify_active;
      if (!verify_active) begin
        key_rd_idx <= '0;
      end else begin
        verify_data <= (lock_bits == 2'h3) ? 8'hFF
                       : ~(code_byte ^ key_mem[key_rd_idx]);
        key_rd_idx  <= key_rd_idx + KEY_IDX_W'(1);
      end
    end
  end

  // lock decode; reserved code 2 alone adds nothing
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_no_internal <= 1'b0;
      program_disable <= 1'b0;
      verify_disable  <= 1'b0;
    end else begin
      ext_no_internal <= lock_bits[LOCK_B1_BIT];
      program_disable <= lock_bits[LOCK_B1_BIT];
      verify_disable  <= lock_bits[LOCK_B1_BIT] & lock_bits[LOCK_B2_BIT];
    end
  end

  // mode-driven pin states and core controls
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cpu_halt                <= 1'b0;
      periph_clk_en           <= 1'b1;
      osc_enable              <= 1'b1;
      ram_we                  <= 1'b0;
      periph_reset            <= 1'b1;
      core_reset              <= 1'b1;
      ale_out                 <= 1'b1;
      ale_oe                  <= 1'b1;
      program_fetch_strobe    <= 1'b1;
      program_fetch_strobe_oe <= 1'b1;
      port0_oe                <= 1'b1;
      weak_pullup             <= 1'b0;
    end else begin
      cpu_halt      <= (state == PMLE_IDLE) || (state == PMLE_PDOWN);
      periph_clk_en <= (state != PMLE_PDOWN);
      osc_enable    <= (state != PMLE_PDOWN);
      // ram writes blocked while halted and in the post-idle reset window
      ram_we        <= ram_we_req && !resume_win && !hw_reset
                       && state == PMLE_RUN;
      periph_reset  <= hw_reset;
      core_reset    <= hw_reset;
      weak_pullup   <= (state == PMLE_EMULATE);
      ale_oe        <= (state != PMLE_EMULATE);
      program_fetch_strobe_oe <= (state != PMLE_EMULATE);
      case (state)
        PMLE_IDLE: begin
          ale_out              <= 1'b1;
          program_fetch_strobe <= 1'b1;
          port0_oe             <= ea_sync[1];
        end
        PMLE_PDOWN: begin
          ale_out              <= 1'b0;
          program_fetch_strobe <= 1'b0;
          port0_oe             <= ea_sync[1];
        end
        PMLE_EMULATE: begin
          ale_out              <= 1'b1;
          program_fetch_strobe <= 1'b1;
          port0_oe             <= 1'b0;
        end
        default: begin
          ale_out              <= 1'b1;
          program_fetch_strobe <= 1'b1;
          port0_oe             <= 1'b1;
        end
      endcase
    end
  end

  // wishbone slave: one wait state, unmapped reads return zero
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge that sees ack high, while the master still holds its data
  assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      case (wb_adr_i)
        ADDR_CTRL:   wb_dat_o <= {30'h0, req_pd, req_idle};
        ADDR_STATUS: wb_dat_o <= {26'h0, ea_latched, resume_win, state};
        ADDR_LOCK:   wb_dat_o <= {30'h0, lock_bits};
        ADDR_KEYIDX: wb_dat_o <= {27'h0, key_wr_idx};
        ADDR_VERIFY: wb_dat_o <= {24'h0, verify_data};
        default:     wb_dat_o <= 32'h0;
      endcase
    end
  end

  // checks
  chk_pd_strobes_low: assert property (@(posedge clock) disable iff (!resetn)
    $past(state) == PMLE_PDOWN && state == PMLE_PDOWN |-> !ale_out && !program_fetch_strobe)
    else $error("strobes not low in power-down");
  chk_idle_strobes_hi: assert property (@(posedge clock) disable iff (!resetn)
    state == PMLE_IDLE |=> ale_out && program_fetch_strobe)
    else $error("strobes not high in idle");
  chk_pd_exit_reset: assert property (@(posedge clock) disable iff (!resetn)
    state == PMLE_PDOWN && !hw_reset |=> state == PMLE_PDOWN)
    else $error("power-down left without reset");
  chk_idle_irq_exit: assert property (@(posedge clock) disable iff (!resetn)
    state == PMLE_IDLE && irq_pending |=> state == PMLE_RUN)
    else $error("idle not left on interrupt");
  chk_pd_priority: assert property (@(posedge clock) disable iff (!resetn)
    state == PMLE_RUN && instr_end && req_pd && !(hw_reset_q && !hw_reset)
    |=> state == PMLE_PDOWN)
    else $error("power-down request not honoured");
  chk_ram_block_win: assert property (@(posedge clock) disable iff (!resetn)
    resume_win |=> !ram_we)
    else $error("ram write in resume window");
  chk_osc_stop_pd: assert property (@(posedge clock) disable iff (!resetn)
    state == PMLE_PDOWN |=> !osc_enable && cpu_halt)
    else $error("oscillator running in power-down");
  chk_verify_off: assert property (@(posedge clock) disable iff (!resetn)
    verify_active && lock_bits == 2'h3 |=> verify_data == 8'hFF)
    else $error("verify data leaked with both locks");
  chk_emu_port0: assert property (@(posedge clock) disable iff (!resetn)
    state == PMLE_EMULATE |=> !port0_oe && weak_pullup && osc_enable)
    else $error("emulation pin states wrong");
  chk_reset_hold: assert property (@(posedge clock) disable iff (!resetn)
    $rose(hw_reset) |-> $past(rst_sync[1], 24))
    else $error("reset recognised too early");
endmodule

// ==== core/pmle_pkg.sv ====
package pmle_pkg;
  // machine cycle is twelve oscillator periods; strobe rate is one sixth
  localparam int MACHINE_CYCLE_CLKS  = 12;
  localparam int RESET_HOLD_MCYC     = 2;
  localparam int RESET_HOLD_CLKS     = MACHINE_CYCLE_CLKS * RESET_HOLD_MCYC;
  localparam int IDLE_RESUME_MCYC    = 2;
  localparam int IDLE_RESUME_CLKS    = MACHINE_CYCLE_CLKS * IDLE_RESUME_MCYC;
  localparam int KEY_BYTES           = 32;
  localparam int KEY_IDX_W           = 5;

  // wishbone register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LOCK   = 8'h08;
  localparam logic [7:0] ADDR_KEYIDX = 8'h0C;
  localparam logic [7:0] ADDR_KEYDAT = 8'h10;
  localparam logic [7:0] ADDR_VERIFY = 8'h14;

  // control register fields
  localparam int CTRL_IDLE_BIT = 0;
  localparam int CTRL_PD_BIT   = 1;
  // lock register fields, a 1 means the bit is programmed
  localparam int LOCK_B1_BIT   = 0;
  localparam int LOCK_B2_BIT   = 1;
  localparam logic [1:0] LOCK_RESET = 2'h0;
  localparam logic [7:0] KEY_RESET  = 8'hFF;

  typedef enum logic [3:0] {
    PMLE_RUN     = 4'h1,
    PMLE_IDLE    = 4'h2,
    PMLE_PDOWN   = 4'h4,
    PMLE_EMULATE = 4'h8
  } pmle_state_t;
endpackage

// ==== verification/pmle_partner.sv ====
// reset circuit, emulator and strap model on the far side of the pins
module pmle_partner
  import pmle_pkg::*;
#(
  parameter int OSC_SETTLE = 8
)
(
  input  wire logic clock,
  input  wire logic rst_req,
  input  wire logic emu_req,
  input  wire logic ea_level,
  output logic      reset_pin,
  output logic      ale_pin,
  output logic      pfs_pin,
  output logic      ea_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int hold  = 0;
  int after = 0;
  initial begin
    reset_pin = 1'b0;
    ale_pin   = 1'b1;
    pfs_pin   = 1'b1;
    ea_pin    = 1'b1;
  end
  // stretch a request so the oscillator can settle past the recognition time
  always @(posedge clock) begin
    if (rst_req) hold <= RESET_HOLD_CLKS + OSC_SETTLE + 4;
    else if (hold > 0) hold <= hold - 1;
    reset_pin <= rst_req || hold > 1;
    if (reset_pin) after <= 6;
    else if (after > 0) after <= after - 1;
    // strobe kept low through reset and a few cycles past its release
    ale_pin <= !(emu_req && (reset_pin || after > 0));
    pfs_pin <= 1'b1;
    ea_pin  <= ea_level;
  end
endmodule

// ==== verification/pmle_ctrl_tb_top.sv ====
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module pmle_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pmle_pkg::*;
  logic        clock = 0, resetn = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0, code = 0, vdata;
  logic [3:0]  sel = 0;
  logic [31:0] dat = 0, rdat, q;
  logic        instr_end = 0, irq = 0, ram_req = 0, vact = 0;
  logic        rst_req = 0, emu_req = 0, ea_level = 1, saw, rs, wr;
  logic        ack, cpu_halt, periph_clk_en, osc_enable, ram_we, periph_reset, core_reset;
  logic        ale_out, ale_oe, pfs, pfs_oe, port0_oe, weak_pullup, ea_latched;
  logic        ext_no_internal, program_disable, verify_disable;
  logic        reset_pin, ale_pin, pfs_pin, ea_pin;
  int          errors = 0, n_tests = 0;

  pmle_ctrl u_pmle_ctrl (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .instr_end(instr_end), .irq_pending(irq), .ram_we_req(ram_req),
    .verify_active(vact), .code_byte(code), .reset_pin(reset_pin),
    .external_access_select(ea_pin), .ale_pin_in(ale_pin), .program_fetch_strobe_in(pfs_pin),
    .cpu_halt(cpu_halt), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
    .ram_we(ram_we), .periph_reset(periph_reset), .core_reset(core_reset),
    .ale_out(ale_out), .ale_oe(ale_oe), .program_fetch_strobe(pfs),
    .program_fetch_strobe_oe(pfs_oe), .port0_oe(port0_oe), .weak_pullup(weak_pullup),
    .ea_latched(ea_latched), .ext_no_internal(ext_no_internal),
    .program_disable(program_disable), .verify_disable(verify_disable),
    .verify_data(vdata));
  pmle_partner u_pmle_partner (.clock(clock), .rst_req(rst_req), .emu_req(emu_req),
    .ea_level(ea_level), .reset_pin(reset_pin), .ale_pin(ale_pin), .pfs_pin(pfs_pin),
    .ea_pin(ea_pin));

  initial begin
    forever #20 clock = ~clock;
  end

  // classic single cycle; request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'h1;
    do begin @(posedge clock); n++; end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 0; stb <= 0;
    if (n >= 50) begin
      $display("FAIL %0t bus request never acknowledged", $time);
      errors++;
      conclude();
    end
  endtask

  task automatic pulse_end();
    @(posedge clock) instr_end <= 1;
    @(posedge clock) instr_end <= 0;
    repeat (3) @(posedge clock);
  endtask

  // pin reset via the partner; watches recognition, resume and ram blocking
  task automatic hwrst(input logic emu);
    @(posedge clock); emu_req <= emu; rst_req <= 1;
    @(posedge clock); rst_req <= 0;
    saw = 0; rs = 0; wr = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clock);
      if (core_reset === 1'b1 && periph_reset === 1'b1) saw = 1;
      if (cpu_halt === 1'b0 && !saw) rs = 1;
      if (i > 4 && !saw && reset_pin && ram_we !== 1'b0) wr = 1;
    end
    `CHK(saw, 1'b1)
    `CHK(core_reset, 1'b0)
  endtask

  task automatic vrf(input logic [7:0] e0, input logic [7:0] e1);
    @(posedge clock) begin vact <= 1; code <= 8'h3C; end
    @(posedge clock); #1;
    `CHK(vdata, e0)
    @(posedge clock); #1;
    `CHK(vdata, e1)
    @(posedge clock) vact <= 0;
  endtask

  task automatic t_regs();
    wb(0, ADDR_LOCK, 0);
    `CHK(q[1:0], LOCK_RESET)
    wb(0, 8'h3C, 0);
    `CHK(q, 32'h0)
    $display("done regs");
  endtask

  task automatic t_idle();
    wb(1, ADDR_CTRL, 32'h1);
    pulse_end();
    `CHK({cpu_halt, periph_clk_en, osc_enable}, 3'b111)
    `CHK({ale_out, pfs, port0_oe}, 3'b111)
    wb(0, ADDR_STATUS, 0);
    `CHK(q[3:0], PMLE_IDLE)
    irq <= 1;
    repeat (4) @(posedge clock);
    `CHK(cpu_halt, 1'b0)
    irq <= 0;
    wb(1, ADDR_CTRL, 0);
    $display("done idle");
  endtask

  // reset out of idle while the cpu keeps asking to write ram
  task automatic t_idle_rst();
    ram_req <= 1;
    wb(1, ADDR_CTRL, 32'h1);
    pulse_end();
    hwrst(0);
    `CHK(rs, 1'b1)
    `CHK(wr, 1'b0)
    repeat (3) @(posedge clock);
    `CHK(ram_we, 1'b1)
    ram_req <= 0;
    $display("done idle reset");
  endtask

  task automatic t_pd();
    ea_level <= 0;
    wb(1, ADDR_CTRL, 32'h3);
    pulse_end();
    `CHK({osc_enable, periph_clk_en, cpu_halt}, 3'b001)
    `CHK({ale_out, pfs, port0_oe}, 3'b000)
    irq <= 1;
    repeat (8) @(posedge clock);
    `CHK(osc_enable, 1'b0)
    irq <= 0;
    hwrst(0);
    `CHK({osc_enable, cpu_halt}, 2'b10)
    ea_level <= 1;
    $display("done power down");
  endtask

  task automatic t_emu();
    hwrst(1);
    repeat (8) @(posedge clock);
    `CHK({ale_oe, pfs_oe, port0_oe, weak_pullup, osc_enable}, 5'b00011)
    hwrst(0);
    repeat (4) @(posedge clock);
    `CHK({weak_pullup, ale_oe}, 2'b01)
    $display("done emulation");
  endtask

  task automatic t_lock();
    wb(1, ADDR_KEYIDX, 0);
    wb(1, ADDR_KEYDAT, 0);
    wb(1, ADDR_KEYDAT, 32'h5A);
    wb(1, ADDR_KEYIDX, 0);
    vrf(8'hC3, 8'h99);
    wb(1, ADDR_LOCK, 32'h2);
    repeat (2) @(posedge clock);
    `CHK({ext_no_internal, program_disable, verify_disable}, 3'b000)
    @(posedge clock) resetn <= 0;
    repeat (16) @(posedge clock);
    resetn <= 1;
    wb(1, ADDR_LOCK, 32'h1);
    repeat (2) @(posedge clock);
    `CHK({ext_no_internal, program_disable, verify_disable}, 3'b110)
    // key writes refused now, so the old keys must still show through
    wb(1, ADDR_KEYIDX, 0);
    wb(1, ADDR_KEYDAT, 32'h11);
    vrf(8'hC3, 8'h99);
    wb(1, ADDR_LOCK, 32'h2);
    repeat (2) @(posedge clock);
    `CHK(verify_disable, 1'b0)
    // both bits in one write, since bit 1 alone refuses further lock writes
    @(posedge clock) resetn <= 0;
    repeat (16) @(posedge clock);
    resetn <= 1;
    wb(1, ADDR_LOCK, 32'h3);
    repeat (2) @(posedge clock);
    `CHK(verify_disable, 1'b1)
    vrf(8'hFF, 8'hFF);
    ea_level <= 0;
    hwrst(0);
    `CHK(ea_latched, 1'b0)
    ea_level <= 1;
    hwrst(0);
    `CHK(ea_latched, 1'b1)
    $display("done lock");
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1;
    t_regs();
    t_idle();
    t_idle_rst();
    t_pd();
    t_emu();
    t_lock();
    conclude();
  end

  // about nineteen times the expected run length
  initial begin
    #400000;
    errors++;
    conclude();
  end
endmodule
